// ===== dpr_defines.svh
// Register offsets, field positions and reset values of the dual-port block memory
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

`define DPR_OFS_CFG_A      8'h00
`define DPR_OFS_OUTPUT_RESET_VALUE_A    8'h04
`define DPR_OFS_INIT_A     8'h08
`define DPR_OFS_CFG_B      8'h0C
`define DPR_OFS_OUTPUT_RESET_VALUE_B    8'h10
`define DPR_OFS_INIT_B     8'h14
`define DPR_OFS_CTRL       8'h18
`define DPR_OFS_LATCH_A    8'h1C
`define DPR_OFS_LATCH_B    8'h20
`define DPR_OFS_LATCH_X    8'h24

`define DPR_CFG_WIDTH_LSB  0
`define DPR_CFG_WIDTH_MSB  2
`define DPR_CFG_MODE_LSB   4
`define DPR_CFG_MODE_MSB   5
`define DPR_CFG_SRX_LSB    8
`define DPR_CFG_SRX_MSB    11
`define DPR_CFG_INX_LSB    12
`define DPR_CFG_INX_MSB    15
`define DPR_CFG_MASK       32'h0000_FF37
`define DPR_CTRL_RELOAD    0

`define DPR_CFG_RST        32'h0000_0005
`define DPR_OUTPUT_RESET_VALUE_RST      32'h0000_0000
`define DPR_INIT_RST       32'h0000_0000
`define DPR_LATCH_D_RST    32'h0000_0000
`define DPR_LATCH_X_RST    4'h0

`define DPR_WIDTH_MAX      3'h5
`define DPR_WORDS          512
`define DPR_DATA_BITS      16384
`define DPR_EXTRA_BITS     2048

`endif

// ===== dpr_pkg.sv
// Types shared by the dual-port block memory
package dpr_pkg;

   typedef enum logic [1:0] {
      DPR_WM_WRITE_FIRST,
      DPR_WM_READ_FIRST,
      DPR_WM_NO_CHANGE
   } dpr_wmode_type;

endpackage : dpr_pkg

// ===== dpr_block_ram.sv
// Dual-port synchronous block memory with AHB-Lite configuration registers
//
// Functional notes
// - Enabled write edge stores word and extras
// - Enabled read edge presents addressed location
// - New-data mode outputs the written data
// - Old-data mode outputs pre-write contents
// - Hold mode keeps latch, memory still written
// - Disabled port: no read, no write
// - Latch clear loads width-sized output reset value
// - Latch clear during write still writes memory
// - Global reload loads start value, memory untouched
// - Data memory preloaded from content strings
// - Extra-bit memory preloaded from its strings
// - Extra bits are plain data, no parity
// - Port width applies to write and read
// - Ports operate independently in same cycle
// - Widths 1,2,4,9,18,36 with 0,0,0,1,2,4 extras
// - Location lines equal 14 minus log2 data width
// - Mixed widths map words, extras follow bytes
// - Widths 4, 2, 1 carry no extras
`timescale 1ns/10ps
`default_nettype none
`include "dpr_defines.svh"

module dpr_block_ram #(
   parameter logic [`DPR_DATA_BITS-1:0]  CONTENT_PRELOAD       = '0,
   parameter logic [`DPR_EXTRA_BITS-1:0] EXTRA_CONTENT_PRELOAD = '0
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Port A
   input  wire logic        port_a_active,
   input  wire logic        port_a_store_request,
   input  wire logic        port_a_latch_clear,
   input  wire logic [13:0] port_a_location,
   input  wire logic [31:0] port_a_write_word,
   input  wire logic [3:0]  port_a_write_extra,
   output logic [31:0]      port_a_read_word,
   output logic [3:0]       port_a_read_extra,
   // Port B
   input  wire logic        port_b_active,
   input  wire logic        port_b_store_request,
   input  wire logic        port_b_latch_clear,
   input  wire logic [13:0] port_b_location,
   input  wire logic [31:0] port_b_write_word,
   input  wire logic [3:0]  port_b_write_extra,
   output logic [31:0]      port_b_read_word,
   output logic [3:0]       port_b_read_extra
);

   // Storage: 512 words of 32 data bits plus 4 extra bits
   logic [31:0] mem_d [`DPR_WORDS];
   logic [3:0]  mem_x [`DPR_WORDS];

   // Configuration registers, one set per port, and the reload pulse shared by both
   logic [1:0][31:0] cfg_r;
   logic [1:0][31:0] output_reset_value_r;
   logic [1:0][31:0] init_r;
   logic             reload_r;

   // Bus pipeline
   logic             wr_pend_r;
   logic             rd_pend_r;
   logic [7:0]       addr_r;
   logic [31:0]      hrdata_r;
   logic             accept;
   logic [31:0]      rd_sel;

   // Per-port views
   logic [1:0]       act;
   logic [1:0]       store;
   logic [1:0]       clr;
   logic [1:0][13:0] loc;
   logic [1:0][31:0] wword;
   logic [1:0][3:0]  wextra;
   logic [1:0]       wr;
   logic [1:0][8:0]  idx;
   logic [1:0][31:0] wm_d;
   logic [1:0][31:0] wd_d;
   logic [1:0][3:0]  wm_x;
   logic [1:0][3:0]  wd_x;
   logic [1:0][31:0] lat_d_r;
   logic [1:0][3:0]  lat_x_r;
   logic [31:0]      merged_a_d;
   logic [3:0]       merged_a_x;
   logic [31:0]      base_b_d;
   logic [3:0]       base_b_x;
   logic [31:0]      merged_b_d;
   logic [3:0]       merged_b_x;

   assign act    = {port_b_active, port_a_active};
   assign store  = {port_b_store_request, port_a_store_request};
   assign clr    = {port_b_latch_clear, port_a_latch_clear};
   assign loc    = {port_b_location, port_a_location};
   assign wword  = {port_b_write_word, port_a_write_word};
   assign wextra = {port_b_write_extra, port_a_write_extra};

   // Port datapaths
   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [2:0]  k;
      logic [2:0]  sh;
      logic [4:0]  sub;
      logic [4:0]  doff;
      logic [1:0]  xoff;
      logic [2:0]  xw;
      logic [31:0] dmask;
      logic [3:0]  xmask;
      logic [31:0] rd_d;
      logic [3:0]  rd_x;
      logic [31:0] new_d;
      logic [3:0]  new_x;
      logic [31:0] lat_d_nxt;
      logic [3:0]  lat_x_nxt;
      logic [3:0]  srx;
      logic [3:0]  inx;
      dpr_pkg::dpr_wmode_type mode;

      // Width code k selects a data width of 2**k; codes above 5 act as 5
      assign k     = (cfg_r[p][`DPR_CFG_WIDTH_MSB:`DPR_CFG_WIDTH_LSB] > `DPR_WIDTH_MAX) ?
                     `DPR_WIDTH_MAX : cfg_r[p][`DPR_CFG_WIDTH_MSB:`DPR_CFG_WIDTH_LSB];
      assign sh    = `DPR_WIDTH_MAX - k;
      // Only the low 14-k location lines count; the upper ones are ignored
      assign idx[p] = 9'(loc[p] >> sh);
      assign sub   = 5'(loc[p] & ((14'h1 << sh) - 14'h1));
      assign doff  = 5'(sub << k);
      assign dmask = 32'hFFFF_FFFF >> (6'd32 - (6'h1 << k));
      assign xw    = (k >= 3'h3) ? 3'(3'h1 << (k - 3'h3)) : 3'h0;
      assign xmask = 4'(4'hF >> (3'h4 - xw));
      // Extra bits follow their byte lane so mixed widths stay aligned
      assign xoff  = (k >= 3'h3) ? 2'(sub << (k - 3'h3)) : 2'h0;
      assign mode  = dpr_pkg::dpr_wmode_type'(cfg_r[p][`DPR_CFG_MODE_MSB:`DPR_CFG_MODE_LSB]);
      // Extras of the clear and start values sit in the config word
      assign srx   = cfg_r[p][`DPR_CFG_SRX_MSB:`DPR_CFG_SRX_LSB];
      assign inx   = cfg_r[p][`DPR_CFG_INX_MSB:`DPR_CFG_INX_LSB];

      // Write bits beyond the port width never reach the array
      assign new_d   = wword[p] & dmask;
      assign new_x   = wextra[p] & xmask;
      assign wm_d[p] = dmask << doff;
      assign wd_d[p] = new_d << doff;
      assign wm_x[p] = xmask << xoff;
      assign wd_x[p] = new_x << xoff;
      assign wr[p]   = act[p] & store[p];
      assign rd_d    = (mem_d[idx[p]] >> doff) & dmask;
      assign rd_x    = (mem_x[idx[p]] >> xoff) & xmask;

      // Next latch value: reload, then clear, then read, then write mode
      always_comb begin
         lat_d_nxt = lat_d_r[p];
         lat_x_nxt = lat_x_r[p];
         if (reload_r) begin
            lat_d_nxt = init_r[p] & dmask;
            lat_x_nxt = inx & xmask;
         end else if (act[p]) begin
            if (clr[p]) begin
               lat_d_nxt = output_reset_value_r[p] & dmask;
               lat_x_nxt = srx & xmask;
            end else if (!store[p]) begin
               lat_d_nxt = rd_d;
               lat_x_nxt = rd_x;
            end else begin
               unique case (mode)
                  dpr_pkg::DPR_WM_WRITE_FIRST: begin
                     lat_d_nxt = new_d;
                     lat_x_nxt = new_x;
                  end
                  dpr_pkg::DPR_WM_READ_FIRST: begin
                     lat_d_nxt = rd_d;
                     lat_x_nxt = rd_x;
                  end
                  dpr_pkg::DPR_WM_NO_CHANGE: begin
                     lat_d_nxt = lat_d_r[p];
                     lat_x_nxt = lat_x_r[p];
                  end
                  default: begin
                     lat_d_nxt = new_d;
                     lat_x_nxt = new_x;
                  end
               endcase
            end
         end
      end

      // Output latch; reads see memory before this edge's writes
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            lat_d_r[p] <= `DPR_LATCH_D_RST;
            lat_x_r[p] <= `DPR_LATCH_X_RST;
         end else begin
            lat_d_r[p] <= lat_d_nxt;
            lat_x_r[p] <= lat_x_nxt;
         end
      end
   end

   // Memory array
   // When both ports hit one word, port B merges onto port A's result, so
   // disjoint lanes both land; on overlapping bits port B wins.
   assign merged_a_d = (mem_d[idx[0]] & ~wm_d[0]) | wd_d[0];
   assign merged_a_x = (mem_x[idx[0]] & ~wm_x[0]) | wd_x[0];
   assign base_b_d   = (wr[0] && idx[0] == idx[1]) ? merged_a_d : mem_d[idx[1]];
   assign base_b_x   = (wr[0] && idx[0] == idx[1]) ? merged_a_x : mem_x[idx[1]];
   assign merged_b_d = (base_b_d & ~wm_d[1]) | wd_d[1];
   assign merged_b_x = (base_b_x & ~wm_x[1]) | wd_x[1];

   // Preloaded contents survive resets; only port writes change them
   initial begin
      for (int i = 0; i < `DPR_WORDS; i++) begin
         mem_d[i] = CONTENT_PRELOAD[i*32 +: 32];
         mem_x[i] = EXTRA_CONTENT_PRELOAD[i*4 +: 4];
      end
   end

   // Plain always block: the array is also written by the preload above
   always @(posedge hclk) begin
      if (wr[0]) begin
         mem_d[idx[0]] <= merged_a_d;
         mem_x[idx[0]] <= merged_a_x;
      end
      if (wr[1]) begin
         mem_d[idx[1]] <= merged_b_d;
         mem_x[idx[1]] <= merged_b_x;
      end
   end

   // Outputs come straight from the latches, never from the array
   assign port_a_read_word  = lat_d_r[0];
   assign port_a_read_extra = lat_x_r[0];
   assign port_b_read_word  = lat_d_r[1];
   assign port_b_read_extra = lat_x_r[1];

   // AHB-Lite slave
   // SEQ is taken like NONSEQ; IDLE and BUSY never start a transfer
   assign accept    = hsel & hready & htrans[1];
   // Reads take one wait state so a write just before is always visible
   assign hreadyout = ~rd_pend_r;
   // Every access is answered OKAY, even to unmapped offsets
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // The address is kept for the data phase that follows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r <= 8'h00;
      end else if (accept) begin
         addr_r <= haddr[7:0];
      end
   end

   // Write data stands on the bus one cycle after its address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= accept & hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_r <= 1'b0;
      end else begin
         rd_pend_r <= accept & ~hwrite;
      end
   end

   // Unmapped offsets and the control word read as zero
   always_comb begin
      rd_sel = 32'h0000_0000;
      unique case (addr_r)
         `DPR_OFS_CFG_A:   rd_sel = cfg_r[0];
         `DPR_OFS_OUTPUT_RESET_VALUE_A: rd_sel = output_reset_value_r[0];
         `DPR_OFS_INIT_A:  rd_sel = init_r[0];
         `DPR_OFS_CFG_B:   rd_sel = cfg_r[1];
         `DPR_OFS_OUTPUT_RESET_VALUE_B: rd_sel = output_reset_value_r[1];
         `DPR_OFS_INIT_B:  rd_sel = init_r[1];
         `DPR_OFS_LATCH_A: rd_sel = lat_d_r[0];
         `DPR_OFS_LATCH_B: rd_sel = lat_d_r[1];
         `DPR_OFS_LATCH_X: rd_sel = {24'h00_0000, lat_x_r[1], lat_x_r[0]};
         default:          rd_sel = 32'h0000_0000;
      endcase
   end

   // Read data stands until the next read completes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_pend_r) begin
         hrdata_r <= rd_sel;
      end
   end

   // One register set per port; writes land at the data-phase edge
   for (genvar p = 0; p < 2; p++) begin : g_regs
      localparam logic [7:0] OFS_CFG   = (p == 0) ? `DPR_OFS_CFG_A : `DPR_OFS_CFG_B;
      localparam logic [7:0] OFS_OUTPUT_RESET_VALUE = (p == 0) ? `DPR_OFS_OUTPUT_RESET_VALUE_A : `DPR_OFS_OUTPUT_RESET_VALUE_B;
      localparam logic [7:0] OFS_INIT  = (p == 0) ? `DPR_OFS_INIT_A : `DPR_OFS_INIT_B;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cfg_r[p]   <= `DPR_CFG_RST;
            output_reset_value_r[p] <= `DPR_OUTPUT_RESET_VALUE_RST;
            init_r[p]  <= `DPR_INIT_RST;
         end else if (wr_pend_r) begin
            if (addr_r == OFS_CFG) begin
               cfg_r[p] <= hwdata & `DPR_CFG_MASK;
            end
            if (addr_r == OFS_OUTPUT_RESET_VALUE) begin
               output_reset_value_r[p] <= hwdata;
            end
            if (addr_r == OFS_INIT) begin
               init_r[p] <= hwdata;
            end
         end
      end
   end

   // Reload is a one-cycle pulse raised by writing the control word with bit 0 set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload_r <= 1'b0;
      end else begin
         reload_r <= wr_pend_r && (addr_r == `DPR_OFS_CTRL) &&
                     hwdata[`DPR_CTRL_RELOAD];
      end
   end

endmodule : dpr_block_ram
`default_nettype wire

// ===== dpr_checker.sv
// Bus and memory-port assertions for the dual-port block memory
`timescale 1ns/10ps
`default_nettype none
module dpr_checker (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Port A
   input wire logic        port_a_active,
   input wire logic        port_a_store_request,
   input wire logic        port_a_latch_clear,
   input wire logic [31:0] port_a_write_word,
   input wire logic [31:0] port_a_read_word,
   input wire logic [3:0]  port_a_read_extra,
   // Port B
   input wire logic        port_b_active,
   input wire logic        port_b_store_request,
   input wire logic        port_b_latch_clear,
   input wire logic [31:0] port_b_write_word,
   input wire logic [31:0] port_b_read_word
);
   logic       acc_w;
   logic [2:0] quiet_r;
   logic       cfg_hit_r;
   assign acc_w = hsel && hready && htrans[1];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A register write may fire a reload, so hold checks wait until that has passed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_r   <= 3'h7;
         cfg_hit_r <= 1'b0;
      end else if (acc_w && hwrite) begin
         quiet_r   <= 3'h0;
         cfg_hit_r <= 1'b1;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   sequence rd_taken; acc_w && !hwrite; endsequence
   sequence rd_wait; !hreadyout ##1 hreadyout; endsequence
   AST_RD_WAIT: assert property (rd_taken |=> rd_wait)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (acc_w && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_OKAY: assert property (acc_w |=> (!hresp)[*2])
      else $error("error response seen");
   AST_HRDATA_HOLD: assert property (hreadyout |=> $stable(hrdata))
      else $error("read data changed without a read");
   AST_A_HOLD: assert property (
      !port_a_active && quiet_r > 3'h4 |=> $stable(port_a_read_word) && $stable(port_a_read_extra))
      else $error("port a output moved while disabled");
   AST_B_HOLD: assert property (!port_b_active && quiet_r > 3'h4 |=> $stable(port_b_read_word))
      else $error("port b output moved while disabled");
   AST_A_WRFIRST: assert property (port_a_active && port_a_store_request && !port_a_latch_clear
      && !cfg_hit_r && !port_b_active |=> port_a_read_word == $past(port_a_write_word))
      else $error("port a new data not shown");
   AST_B_WRFIRST: assert property (port_b_active && port_b_store_request && !port_b_latch_clear
      && !cfg_hit_r && !port_a_active |=> port_b_read_word == $past(port_b_write_word))
      else $error("port b new data not shown");
endmodule : dpr_checker
`default_nettype wire

// ===== dpr_port_driver.sv
// User logic model that drives both memory ports
`timescale 1ns/10ps
`default_nettype none
module dpr_port_driver (
   // Clock
   input wire logic   hclk,
   // Port A
   output logic        port_a_active,
   output logic        port_a_store_request,
   output logic        port_a_latch_clear,
   output logic [13:0] port_a_location,
   output logic [31:0] port_a_write_word,
   output logic [3:0]  port_a_write_extra,
   // Port B
   output logic        port_b_active,
   output logic        port_b_store_request,
   output logic        port_b_latch_clear,
   output logic [13:0] port_b_location,
   output logic [31:0] port_b_write_word,
   output logic [3:0]  port_b_write_extra
);
   initial begin
      {port_a_active, port_a_store_request, port_a_latch_clear, port_a_location} = '0;
      {port_a_write_word, port_a_write_extra, port_b_write_word, port_b_write_extra} = '0;
      {port_b_active, port_b_store_request, port_b_latch_clear, port_b_location} = '0;
   end
   task automatic op(input logic [1:0] sel, input logic act, input logic st, input logic clr,
                     input logic [13:0] loc, input logic [31:0] wd, input logic [3:0] wx);
      @(posedge hclk);
      if (sel[0]) begin
         {port_a_active, port_a_store_request, port_a_latch_clear} <= {act, st, clr};
         {port_a_location, port_a_write_word, port_a_write_extra} <= {loc, wd, wx};
      end
      if (sel[1]) begin
         {port_b_active, port_b_store_request, port_b_latch_clear} <= {act, st, clr};
         {port_b_location, port_b_write_word, port_b_write_extra} <= {loc, wd, wx};
      end
      @(posedge hclk);
      // Released data shows inverted junk, so a stale copy cannot pass by luck
      {port_a_active, port_a_store_request, port_a_latch_clear} <= 3'h0;
      {port_b_active, port_b_store_request, port_b_latch_clear} <= 3'h0;
      {port_a_write_word, port_b_write_word} <= {~wd, ~wd};
      #1;
   endtask : op
endmodule : dpr_port_driver
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the dual-port block memory
`timescale 1ns/10ps
`default_nettype none
`include "dpr_defines.svh"
module tb;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize = 3'h2;
   logic        port_a_active, port_a_store_request, port_a_latch_clear;
   logic        port_b_active, port_b_store_request, port_b_latch_clear;
   logic [13:0] port_a_location, port_b_location;
   logic [31:0] port_a_write_word, port_b_write_word, port_a_read_word, port_b_read_word;
   logic [3:0]  port_a_write_extra, port_b_write_extra, port_a_read_extra, port_b_read_extra;
   int          mismatches;
   int          n_compared;
   assign hready = hreadyout;
   dpr_block_ram #(
      .CONTENT_PRELOAD      (16384'hCAFE0005 << 160),
      .EXTRA_CONTENT_PRELOAD(2048'hA << 20)
   ) dut (.*);
   dpr_port_driver p (.*);
   always #5 hclk = ~hclk;
   function automatic logic [35:0] oa();
      return {port_a_read_extra, port_a_read_word};
   endfunction : oa
   function automatic logic [35:0] ob();
      return {port_b_read_extra, port_b_read_word};
   endfunction : ob
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic stop_test;
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
   initial begin
      {hclk, hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
      mismatches = 0;
      n_compared = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd5, 32'h0, 4'h0);
      chk(oa(), {4'hA, 32'hCAFE0005});
      p.op(2'h2, 1'b1, 1'b1, 1'b0, 14'd6, 32'h0BADF00D, 4'h2);
      chk(ob(), {4'h2, 32'h0BADF00D});
      p.op(2'h1, 1'b1, 1'b1, 1'b0, 14'd3, 32'h11223344, 4'h5);
      chk(oa(), {4'h5, 32'h11223344});
      p.op(2'h3, 1'b1, 1'b0, 1'b0, 14'd3, 32'h0, 4'h0);
      chk(ob(), {4'h5, 32'h11223344});
      chk(oa(), {4'h5, 32'h11223344});
      bus(1'b1, `DPR_OFS_CFG_A, 32'h15);
      bus(1'b0, `DPR_OFS_CFG_A, 32'h0);
      chk({4'h0, rd}, 36'h15);
      bus(1'b0, `DPR_OFS_CFG_B, 32'h0);
      chk({4'h0, rd}, 36'h5);
      p.op(2'h1, 1'b1, 1'b1, 1'b0, 14'd3, 32'h55667788, 4'h3);
      chk(oa(), {4'h5, 32'h11223344});
      bus(1'b1, `DPR_OFS_CFG_A, 32'h25);
      p.op(2'h1, 1'b1, 1'b1, 1'b0, 14'd3, 32'h99AABBCC, 4'hC);
      chk(oa(), {4'h5, 32'h11223344});
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd3, 32'h0, 4'h0);
      chk(oa(), {4'hC, 32'h99AABBCC});
      p.op(2'h1, 1'b0, 1'b1, 1'b0, 14'd3, 32'h0, 4'h0);
      p.op(2'h1, 1'b0, 1'b0, 1'b0, 14'd5, 32'h0, 4'h0);
      chk(oa(), {4'hC, 32'h99AABBCC});
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd3, 32'h0, 4'h0);
      chk(oa(), {4'hC, 32'h99AABBCC});
      bus(1'b1, `DPR_OFS_OUTPUT_RESET_VALUE_A, 32'h12345678);
      bus(1'b1, `DPR_OFS_CFG_A, 32'h0F05);
      p.op(2'h1, 1'b1, 1'b1, 1'b1, 14'd4, 32'hDEADBEEF, 4'h3);
      chk(oa(), {4'hF, 32'h12345678});
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd4, 32'h0, 4'h0);
      chk(oa(), {4'h3, 32'hDEADBEEF});
      bus(1'b1, `DPR_OFS_CFG_B, 32'h3);
      p.op(2'h2, 1'b1, 1'b0, 1'b0, 14'd17, 32'h0, 4'h0);
      chk(ob(), {4'h1, 32'hBE});
      p.op(2'h2, 1'b1, 1'b1, 1'b0, 14'd18, 32'h5A, 4'h1);
      chk(ob(), {4'h1, 32'h5A});
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd4, 32'h0, 4'h0);
      chk(oa(), {4'h7, 32'hDE5ABEEF});
      bus(1'b1, `DPR_OFS_CFG_B, 32'h2);
      p.op(2'h2, 1'b1, 1'b0, 1'b0, 14'd33, 32'h0, 4'hF);
      chk(ob(), {4'h0, 32'hE});
      bus(1'b1, `DPR_OFS_INIT_A, 32'hA5A5A5A5);
      bus(1'b1, `DPR_OFS_CTRL, 32'h1);
      repeat (3) @(posedge hclk);
      #1;
      chk(oa(), {4'h0, 32'hA5A5A5A5});
      p.op(2'h1, 1'b1, 1'b0, 1'b0, 14'd4, 32'h0, 4'h0);
      chk(oa(), {4'h7, 32'hDE5ABEEF});
      bus(1'b0, 8'h30, 32'h0);
      chk({4'h0, rd}, 36'h0);
      stop_test;
   end
endmodule : tb
bind dpr_block_ram dpr_checker chk_i (.*);
`default_nettype wire
